/* rtl/cwg_ctrl.sv */
// Purpose: Complementary waveform generator with dead band and auto-shutdown
// Assumes: Avalon-MM slave on clk; comparator, fault and oscillator are asynchronous
// Notes:   Pins carry output and enable; the pad resolves the wire
//
// Operation
// R01: Override codes 11 high, 10 low, 01 float
// R02: Code 00 goes inactive after dead band
// R03: Polarity never alters fixed override levels
// R04: Bit 6 selects automatic or software restart
// R05: Software clear needs all enabled sources inactive
// R06: Overrides hold until next input rising edge
// R07: Auto-restart clears status when sources inactive
// R08: Bit 7 turns the generator on
// R09: Pin enables connect outputs A and B
// R10: Polarity bits invert outputs A and B
// R11: Bit 0 selects fast oscillator as clock
// R12: Source field selects PWM1-3 or comparator
// R13: Status bit reads one during shutdown
// R14: Comparator high forces shutdown when enabled
// R15: Fault input low forces shutdown when enabled
// R16: Dead band lasts N to N+1 counts
// R17: Zero falling count bypasses falling dead band
// R18: Software follows the synchronous start sequence
// R19: Software sets overrides before enabling generator
// R20: Software starts by auto-restart or clearing status
// R21: Rising edge: B off, A after delay
// R22: Falling edge: A off, B after delay
// R23: Shutdown inputs act on level
// R24: Software setting status forces shutdown
// R25: Reserved source reads as constantly inactive
`timescale 1ns/10ps
`include "cwg_consts.svh"

module cwg_ctrl (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire cwg_pkg::av_req_t av_req,
  output cwg_pkg::av_resp_t     av_resp,
  input  wire logic             pwm1_out,
  input  wire logic             pwm2_out,
  input  wire logic             pwm3_out,
  input  wire logic             comparator_async_out,
  input  wire logic             fault_input,
  input  wire logic             fast_internal_oscillator,
  output cwg_pkg::pins_t        pins
);
  import cwg_pkg::*;

  state_t     s_reg;
  state_t     s_next;
  logic       wr_hit;
  logic [7:0] wd;
  logic       src_level;
  logic       src_rise;
  logic       src_fall;
  logic       sd_source;
  logic       tick;
  logic       hold;
  logic [1:0] ovr_a;
  logic [1:0] ovr_b;
  logic       lvl_a;
  logic       lvl_b;

  // Request answered one cycle after it appears
  // Clock enable low stalls the answer as well
  assign av_resp.waitrequest = (av_req.read | av_req.write) & ~(s_reg.ack & ce);
  assign av_resp.readdata    = s_reg.rdata;
  assign pins                = s_reg.pins;

  assign wr_hit = av_req.write & s_reg.ack & av_req.byteenable[0];
  assign wd     = av_req.writedata[7:0];

  always_comb begin
    case (s_reg.control_1[`CWG_POS_SOURCE +: 3]) // R12
      `CWG_SRC_COMPARATOR: src_level = s_reg.cmp_filt;
      `CWG_SRC_PWM1:       src_level = pwm1_out;
      `CWG_SRC_PWM2:       src_level = pwm2_out;
      `CWG_SRC_PWM3:       src_level = pwm3_out;
      default:             src_level = 1'b0; // R25
    endcase
  end

  assign src_rise  = src_level & ~s_reg.src_prev;
  assign src_fall  = ~src_level & s_reg.src_prev;
  assign sd_source = (s_reg.comparator_shutdown_on & s_reg.cmp_filt)    // R14
                   | (s_reg.fault_pin_shutdown_on & ~s_reg.flt_filt);   // R15
  // Dead-band counts step on fast oscillator rising edges or every clk
  assign tick      = s_reg.control_0[`CWG_BIT_CLOCK_SELECT]            // R11
                   ? (s_reg.osc_filt & ~s_reg.osc_prev) : 1'b1;
  assign hold      = s_reg.shutdown_status | s_reg.resume_wait;        // R06

  always_comb begin
    s_next = s_reg;
    ovr_a  = 2'h0;
    ovr_b  = 2'h0;
    lvl_a  = 1'b0;
    lvl_b  = 1'b0;
    if (ce) begin
      // Three-stage input capture; change taken when last two agree
      s_next.cmp_sync = {s_reg.cmp_sync[1:0], comparator_async_out};
      s_next.flt_sync = {s_reg.flt_sync[1:0], fault_input};
      s_next.osc_sync = {s_reg.osc_sync[1:0], fast_internal_oscillator};
      if (s_reg.cmp_sync[1] == s_reg.cmp_sync[2]) begin
        s_next.cmp_filt = s_reg.cmp_sync[2];
      end
      if (s_reg.flt_sync[1] == s_reg.flt_sync[2]) begin
        s_next.flt_filt = s_reg.flt_sync[2];
      end
      if (s_reg.osc_sync[1] == s_reg.osc_sync[2]) begin
        s_next.osc_filt = s_reg.osc_sync[2];
      end
      s_next.osc_prev = s_reg.osc_filt;
      s_next.src_prev = src_level;

      // Bus answer and register writes
      s_next.ack   = (av_req.read | av_req.write) & ~s_reg.ack;
      s_next.rdata = 32'h0000_0000;
      if (av_req.read & ~s_reg.ack) begin
        case (av_req.address)
          `CWG_OFS_CONTROL_0: s_next.rdata[7:0] = s_reg.control_0 & `CWG_MASK_CONTROL_0;
          `CWG_OFS_CONTROL_1: s_next.rdata[7:0] = s_reg.control_1 & `CWG_MASK_CONTROL_1;
          `CWG_OFS_SHUTDOWN: begin
            s_next.rdata[`CWG_BIT_SD_STATUS]    = s_reg.shutdown_status; // R13
            s_next.rdata[`CWG_BIT_AUTO_RESTART] = s_reg.auto_restart_on;
            s_next.rdata[`CWG_BIT_CMP_SD_ON]    = s_reg.comparator_shutdown_on;
            s_next.rdata[`CWG_BIT_FLT_SD_ON]    = s_reg.fault_pin_shutdown_on;
          end
          `CWG_OFS_RISE_DB:   s_next.rdata[5:0] = s_reg.rising_deadband_value;
          `CWG_OFS_FALL_DB:   s_next.rdata[5:0] = s_reg.falling_deadband_value;
          default:            s_next.rdata = 32'h0000_0000;
        endcase
      end
      if (wr_hit) begin
        case (av_req.address)
          `CWG_OFS_CONTROL_0: s_next.control_0 = wd & `CWG_MASK_CONTROL_0;
          `CWG_OFS_CONTROL_1: s_next.control_1 = wd & `CWG_MASK_CONTROL_1;
          `CWG_OFS_SHUTDOWN: begin
            s_next.auto_restart_on        = wd[`CWG_BIT_AUTO_RESTART]; // R04
            s_next.comparator_shutdown_on = wd[`CWG_BIT_CMP_SD_ON];
            s_next.fault_pin_shutdown_on  = wd[`CWG_BIT_FLT_SD_ON];
          end
          `CWG_OFS_RISE_DB:   s_next.rising_deadband_value  = wd[5:0];
          `CWG_OFS_FALL_DB:   s_next.falling_deadband_value = wd[5:0];
          default:            s_next.control_0 = s_reg.control_0;
        endcase
      end

      // Shutdown status; a live source always wins over any clear
      if (sd_source) begin
        s_next.shutdown_status = 1'b1; // R23
      end else if (wr_hit && av_req.address == `CWG_OFS_SHUTDOWN && wd[`CWG_BIT_SD_STATUS]) begin
        s_next.shutdown_status = 1'b1; // R24
      end else if (s_reg.auto_restart_on) begin
        s_next.shutdown_status = 1'b0; // R07
      end else if (wr_hit && av_req.address == `CWG_OFS_SHUTDOWN) begin
        s_next.shutdown_status = 1'b0; // R05
      end

      if (s_reg.shutdown_status) begin
        s_next.resume_wait = 1'b1; // R06
      end else if (src_rise) begin
        s_next.resume_wait = 1'b0; // R06
      end

      // Dead-band engine
      if (!s_reg.control_0[`CWG_BIT_MODULE_ON]) begin
        s_next.wave  = ST_OFF; // R08
        s_next.raw_a = 1'b0;
        s_next.raw_b = 1'b0;
      end else if (hold && !(s_reg.resume_wait && !s_reg.shutdown_status && src_rise)) begin
        s_next.raw_a = 1'b0; // R02
        if (s_reg.wave != ST_SD_DB && s_reg.wave != ST_OFF) begin
          s_next.db_count = 7'h00;
          if (s_reg.falling_deadband_value == 6'h00) begin
            s_next.raw_b = 1'b0; // R17
            s_next.wave  = ST_OFF;
          end else begin
            s_next.wave = ST_SD_DB;
          end
        end else if (s_reg.wave == ST_SD_DB) begin
          if (tick) begin
            s_next.db_count = s_reg.db_count + 7'h01;
          end
          if (s_reg.db_count == {1'b0, s_reg.falling_deadband_value}) begin
            s_next.raw_b = 1'b0; // R02
            s_next.wave  = ST_OFF;
          end
        end
      end else if (src_rise) begin
        s_next.raw_b    = 1'b0; // R21
        s_next.db_count = 7'h00;
        if (s_reg.rising_deadband_value == 6'h00) begin
          s_next.raw_a = 1'b1; // R16
          s_next.wave  = ST_A_ON;
        end else begin
          s_next.raw_a = 1'b0;
          s_next.wave  = ST_RISE_DB;
        end
      end else if (src_fall) begin
        s_next.raw_a    = 1'b0; // R22
        s_next.db_count = 7'h00;
        if (s_reg.falling_deadband_value == 6'h00) begin
          s_next.raw_b = 1'b1; // R17
          s_next.wave  = ST_B_ON;
        end else begin
          s_next.raw_b = 1'b0;
          s_next.wave  = ST_FALL_DB;
        end
      end else begin
        case (s_reg.wave)
          ST_RISE_DB: begin
            if (tick) begin
              s_next.db_count = s_reg.db_count + 7'h01;
            end
            if (s_reg.db_count == {1'b0, s_reg.rising_deadband_value}) begin
              s_next.raw_a = 1'b1; // R21
              s_next.wave  = ST_A_ON;
            end
          end
          ST_FALL_DB: begin
            if (tick) begin
              s_next.db_count = s_reg.db_count + 7'h01;
            end
            if (s_reg.db_count == {1'b0, s_reg.falling_deadband_value}) begin
              s_next.raw_b = 1'b1; // R22
              s_next.wave  = ST_B_ON;
            end
          end
          ST_SD_DB: s_next.wave = ST_OFF;
          ST_A_ON:  s_next.wave = ST_A_ON;
          ST_B_ON:  s_next.wave = ST_B_ON;
          ST_OFF:   s_next.wave = ST_OFF;
          default: begin
            s_next.wave  = ST_OFF;
            s_next.raw_a = 1'b0;
            s_next.raw_b = 1'b0;
          end
        endcase
      end

      // Pin drive from the next-state waveform and overrides
      ovr_a = s_next.control_1[`CWG_POS_OVR_A +: 2];
      ovr_b = s_next.control_1[`CWG_POS_OVR_B +: 2];
      lvl_a = s_next.raw_a ^ s_next.control_0[`CWG_BIT_OUT_A_INVERT]; // R10
      lvl_b = s_next.raw_b ^ s_next.control_0[`CWG_BIT_OUT_B_INVERT]; // R10
      s_next.pins.output_a_oe = s_next.control_0[`CWG_BIT_MODULE_ON]
                              & s_next.control_0[`CWG_BIT_OUT_A_PIN_EN]; // R09
      s_next.pins.output_b_oe = s_next.control_0[`CWG_BIT_MODULE_ON]
                              & s_next.control_0[`CWG_BIT_OUT_B_PIN_EN]; // R09
      s_next.pins.output_a    = lvl_a;
      s_next.pins.output_b    = lvl_b;
      if (s_next.shutdown_status | s_next.resume_wait) begin
        case (ovr_a) // R01
          `CWG_OVR_HIGH:  s_next.pins.output_a = 1'b1; // R03
          `CWG_OVR_LOW:   s_next.pins.output_a = 1'b0; // R03
          `CWG_OVR_FLOAT: s_next.pins.output_a_oe = 1'b0;
          default:        s_next.pins.output_a = lvl_a; // R02
        endcase
        case (ovr_b) // R01
          `CWG_OVR_HIGH:  s_next.pins.output_b = 1'b1; // R03
          `CWG_OVR_LOW:   s_next.pins.output_b = 1'b0; // R03
          `CWG_OVR_FLOAT: s_next.pins.output_b_oe = 1'b0;
          default:        s_next.pins.output_b = lvl_b; // R02
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg                        <= '0;
      s_reg.control_0              <= `CWG_RST_CONTROL_0;
      s_reg.control_1              <= `CWG_RST_CONTROL_1;
      s_reg.shutdown_status        <= 1'(`CWG_RST_SHUTDOWN >> `CWG_BIT_SD_STATUS);
      s_reg.rising_deadband_value  <= `CWG_RST_DEADBAND;
      s_reg.falling_deadband_value <= `CWG_RST_DEADBAND;
      s_reg.flt_filt               <= 1'b1;
      s_reg.flt_sync               <= 3'h7;
      s_reg.wave                   <= ST_OFF;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : cwg_ctrl

/* rtl/cwg_consts.svh */
// Purpose: Register offsets, field positions and reset values of the waveform generator
// Assumes: Avalon-MM byte addresses, one 32-bit word per 8-bit register
// Notes:   Definitions only
`ifndef CWG_CONSTS_SVH
`define CWG_CONSTS_SVH

`define CWG_OFS_CONTROL_0     5'h00
`define CWG_OFS_CONTROL_1     5'h04
`define CWG_OFS_SHUTDOWN      5'h08
`define CWG_OFS_RISE_DB       5'h0c
`define CWG_OFS_FALL_DB       5'h10

`define CWG_BIT_MODULE_ON     7
`define CWG_BIT_OUT_B_PIN_EN  6
`define CWG_BIT_OUT_A_PIN_EN  5
`define CWG_BIT_OUT_B_INVERT  4
`define CWG_BIT_OUT_A_INVERT  3
`define CWG_BIT_CLOCK_SELECT  0

`define CWG_POS_OVR_B         6
`define CWG_POS_OVR_A         4
`define CWG_POS_SOURCE        0

`define CWG_BIT_SD_STATUS     7
`define CWG_BIT_AUTO_RESTART  6
`define CWG_BIT_CMP_SD_ON     2
`define CWG_BIT_FLT_SD_ON     1

`define CWG_RST_CONTROL_0     8'h00
`define CWG_RST_CONTROL_1     8'h00
`define CWG_RST_SHUTDOWN      8'h00
`define CWG_RST_DEADBAND      6'h00

`define CWG_MASK_CONTROL_0    8'hf9
`define CWG_MASK_CONTROL_1    8'hf7
`define CWG_MASK_SHUTDOWN     8'hc6
`define CWG_MASK_DEADBAND     8'h3f

`define CWG_OVR_HIGH          2'h3
`define CWG_OVR_LOW           2'h2
`define CWG_OVR_FLOAT         2'h1
`define CWG_OVR_DEADBAND      2'h0

`define CWG_SRC_COMPARATOR    3'h0
`define CWG_SRC_PWM1          3'h2
`define CWG_SRC_PWM2          3'h3
`define CWG_SRC_PWM3          3'h4

`endif

/* rtl/cwg_pkg.sv */
// Purpose: Types of the complementary waveform generator
// Assumes: Constants come from cwg_consts.svh
// Notes:   Bus carriers keep the published Avalon-MM signal names
package cwg_pkg;

  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } av_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } av_resp_t;

  typedef struct packed {
    logic output_a;
    logic output_a_oe;
    logic output_b;
    logic output_b_oe;
  } pins_t;

  typedef enum logic [5:0] {
    ST_OFF     = 6'h01,
    ST_RISE_DB = 6'h02,
    ST_A_ON    = 6'h04,
    ST_FALL_DB = 6'h08,
    ST_B_ON    = 6'h10,
    ST_SD_DB   = 6'h20
  } wave_state_t;

  typedef struct packed {
    logic [7:0]  control_0;
    logic [7:0]  control_1;
    logic        shutdown_status;
    logic        auto_restart_on;
    logic        comparator_shutdown_on;
    logic        fault_pin_shutdown_on;
    logic [5:0]  rising_deadband_value;
    logic [5:0]  falling_deadband_value;
    logic [2:0]  cmp_sync;
    logic        cmp_filt;
    logic [2:0]  flt_sync;
    logic        flt_filt;
    logic [2:0]  osc_sync;
    logic        osc_filt;
    logic        osc_prev;
    logic        src_prev;
    logic        resume_wait;
    wave_state_t wave;
    logic [6:0]  db_count;
    logic        raw_a;
    logic        raw_b;
    logic        ack;
    logic [31:0] rdata;
    pins_t       pins;
  } state_t;

endpackage : cwg_pkg

/* testbench/cwg_ctrl_chk.sv */
// Purpose: Port checks of the waveform generator
// Assumes: Register bytes tracked from accepted bus writes
// Notes:   Pins and tracked settings change at the same edge
`timescale 1ns/10ps
module cwg_ctrl_chk (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic              ce,
  input wire cwg_pkg::av_req_t  av_req,
  input wire cwg_pkg::av_resp_t av_resp,
  input wire logic              comparator_async_out,
  input wire logic              fault_input,
  input wire cwg_pkg::pins_t    pins
);
  import cwg_pkg::*;
  logic [7:0] c0_reg, c1_reg, sd_reg;
  logic       take;
  assign take = ce && av_req.write && !av_resp.waitrequest && av_req.byteenable[0];
  always_ff @(posedge clk) begin
    if (srst) begin
      c0_reg <= 8'h00;
      c1_reg <= 8'h00;
      sd_reg <= 8'h00;
    end else if (take) begin
      if (av_req.address == 5'h00) c0_reg <= av_req.writedata[7:0];
      if (av_req.address == 5'h04) c1_reg <= av_req.writedata[7:0];
      if (av_req.address == 5'h08) sd_reg <= av_req.writedata[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_bus_answer: assert property ($rose(av_req.read || av_req.write) && ce
    |-> av_resp.waitrequest ##1 (!ce || !av_resp.waitrequest)) else $error("late bus answer");
  a_stall_wait: assert property ((av_req.read || av_req.write) && !ce |-> av_resp.waitrequest)
    else $error("answer while stalled");
  a_idle_free: assert property (!(av_req.read || av_req.write) |-> !av_resp.waitrequest)
    else $error("wait while idle");
  a_rdata_top: assert property (av_req.read && !av_resp.waitrequest |-> av_resp.readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_no_overlap: assert property (c0_reg[7:5] == 3'h7 && c1_reg[7:4] == 4'h0
    |-> !((pins.output_a ^ c0_reg[3]) && (pins.output_b ^ c0_reg[4])))
    else $error("both outputs active");
  a_a_fixed: assert property ((c0_reg[7] && c0_reg[5] && sd_reg[1]
    && c1_reg[5] && !fault_input)[*8] |-> pins.output_a == c1_reg[4] && pins.output_a_oe)
    else $error("output a override wrong");
  a_b_fixed: assert property ((c0_reg[7] && c0_reg[6] && sd_reg[2]
    && c1_reg[7] && comparator_async_out)[*8] |-> pins.output_b == c1_reg[6] && pins.output_b_oe)
    else $error("output b override wrong");
  a_b_float: assert property ((c1_reg[7:6] == 2'h1 && sd_reg[2] && comparator_async_out)[*8]
    |-> !pins.output_b_oe) else $error("output b not released");
  a_a_release: assert property (!(c0_reg[7] && c0_reg[5]) |-> !pins.output_a_oe)
    else $error("output a driven while off");
  a_b_release: assert property (!(c0_reg[7] && c0_reg[6]) |-> !pins.output_b_oe)
    else $error("output b driven while off");
endmodule : cwg_ctrl_chk
bind cwg_ctrl cwg_ctrl_chk cwg_ctrl_chk_inst (.clk(clk), .srst(srst), .ce(ce), .av_req(av_req),
  .av_resp(av_resp), .comparator_async_out(comparator_async_out), .fault_input(fault_input), .pins(pins));

/* testbench/switch_pair.sv */
// Purpose: Model of the two power switch drivers
// Assumes: No pull resistor on either pin
// Notes:   A released pin shows the inverse of its last level
`timescale 1ns/10ps
module switch_pair (
  input  wire logic           clk,
  input  wire cwg_pkg::pins_t pins,
  output logic                lvl_a,
  output logic                lvl_b
);
  import cwg_pkg::*;
  logic last_a_reg = 1'b0;
  logic last_b_reg = 1'b0;
  always @(posedge clk) begin
    if (pins.output_a_oe) last_a_reg <= pins.output_a;
    if (pins.output_b_oe) last_b_reg <= pins.output_b;
  end
  assign lvl_a = pins.output_a_oe ? pins.output_a : ~last_a_reg;
  assign lvl_b = pins.output_b_oe ? pins.output_b : ~last_b_reg;
endmodule : switch_pair

/* testbench/tb_top.sv */
// Purpose: Self-checking bench of the waveform generator
// Assumes: Bus answers one cycle after a request
// Notes:   A watcher compares reads and pin probes with queued notes
`timescale 1ns/10ps
`include "cwg_consts.svh"
module tb_top;
  import cwg_pkg::*;
  logic        clk = 0, srst = 1, ce = 1, osc = 0, fault_input = 1, cmp = 0, probe = 0, lvl_a, lvl_b;
  logic [2:0]  pwm = 3'h0;
  av_req_t     av_req = '0;
  av_resp_t    av_resp;
  pins_t       pins;
  logic [31:0] exp_q[$];
  string       nam_q[$];
  logic [7:0]  msk[6] = '{8'hf9, 8'hf7, 8'h00, 8'h3f, 8'h3f, 8'h00};
  int          n_fail = 0, checked = 0, n, i, k;
  always #5 clk = ~clk;
  always #31.25 osc = ~osc;
  cwg_ctrl cwg_ctrl_inst (.clk(clk), .srst(srst), .ce(ce), .av_req(av_req), .av_resp(av_resp),
    .pwm1_out(pwm[0]), .pwm2_out(pwm[1]), .pwm3_out(pwm[2]), .comparator_async_out(cmp),
    .fault_input(fault_input), .fast_internal_oscillator(osc), .pins(pins));
  switch_pair switch_pair_inst (.clk(clk), .pins(pins), .lvl_a(lvl_a), .lvl_b(lvl_b));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  always @(posedge clk) begin
    if (av_req.read && av_resp.waitrequest === 1'b0) chk(nam_q.pop_front(), av_resp.readdata, exp_q.pop_front());
    if (probe) chk(nam_q.pop_front(), {28'h0, lvl_a & pins.output_a_oe, pins.output_a_oe,
      lvl_b & pins.output_b_oe, pins.output_b_oe}, exp_q.pop_front());
  end
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
    av_req <= '{a, !w, w, {24'h0, d}, 4'h1};
    do @(posedge clk); while (av_resp.waitrequest !== 1'b0);
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    nam_q.push_back($sformatf("reg_%h", a));
    bus(a, 1'b0, 8'h00);
  endtask : rd
  task automatic pin_exp(input logic [3:0] e);
    exp_q.push_back({28'h0, e});
    nam_q.push_back("pins");
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
    @(posedge clk);
  endtask : pin_exp
  task automatic step(input int c);
    repeat (c) @(posedge clk);
  endtask : step
  initial begin
    step(30000);
    n_fail++;
    wrap_up();
  end
  initial begin
    step(16);
    srst <= 1'b0;
    step(1);
    void'($urandom(63));
    n = 3 + $urandom % 38;
    for (i = 0; i < 6; i++) rd(5'(i * 4), 8'h00);
    for (i = 0; i < 6; i++) begin
      wr(5'(i * 4), 8'hff);
      if (i != 2) rd(5'(i * 4), msk[i]);
    end
    for (i = 0; i < 6; i++) wr(5'(i * 4), 8'h00);
    // Clock enable low in mid request stalls the write
    fork
      begin
        step(1);
        ce <= 1'b0;
        step(6);
        ce <= 1'b1;
      end
      wr(`CWG_OFS_RISE_DB, 8'h15);
    join
    rd(`CWG_OFS_RISE_DB, 8'h15);
    wr(`CWG_OFS_SHUTDOWN, 8'h82);
    wr(`CWG_OFS_CONTROL_1, 8'h02);
    wr(`CWG_OFS_CONTROL_0, 8'he0);
    pin_exp(4'h5);
    rd(`CWG_OFS_SHUTDOWN, 8'h82);
    wr(`CWG_OFS_SHUTDOWN, 8'h02);
    rd(`CWG_OFS_SHUTDOWN, 8'h02);
    for (i = 0; i < 2; i++) begin
      k = i ? 63 : n;
      wr(`CWG_OFS_RISE_DB, 8'(k));
      rd(`CWG_OFS_RISE_DB, 8'(k));
      pwm <= 3'h1;
      step(k - 1);
      pin_exp(4'h5);
      step(2);
      pin_exp(4'hd);
      pwm <= 3'h0;
      step(2);
      pin_exp(4'h7);
    end
    // Nonzero falling dead band, then shutdown with override 00
    wr(`CWG_OFS_FALL_DB, 8'h04);
    pwm <= 3'h1;
    step(70);
    pwm <= 3'h0;
    step(1);
    pin_exp(4'h5);
    step(4);
    pin_exp(4'h7);
    wr(`CWG_OFS_SHUTDOWN, 8'h80);
    pin_exp(4'h7);
    step(4);
    pin_exp(4'h5);
    wr(`CWG_OFS_SHUTDOWN, 8'h00);
    wr(`CWG_OFS_FALL_DB, 8'h00);
    wr(`CWG_OFS_RISE_DB, 8'h03);
    wr(`CWG_OFS_CONTROL_0, 8'he1);
    pwm <= 3'h1;
    step(9);
    pin_exp(4'h5);
    step(40);
    pin_exp(4'hd);
    pwm <= 3'h0;
    step(10);
    pin_exp(4'h7);
    wr(`CWG_OFS_CONTROL_1, 8'hb2);
    wr(`CWG_OFS_SHUTDOWN, 8'h82);
    pin_exp(4'hd);
    wr(`CWG_OFS_CONTROL_0, 8'hf8);
    pin_exp(4'hd);
    fault_input <= 1'b0;
    step(8);
    wr(`CWG_OFS_SHUTDOWN, 8'h02);
    rd(`CWG_OFS_SHUTDOWN, 8'h82);
    fault_input <= 1'b1;
    step(8);
    wr(`CWG_OFS_SHUTDOWN, 8'h02);
    rd(`CWG_OFS_SHUTDOWN, 8'h02);
    pin_exp(4'hd);
    pwm <= 3'h1;
    step(12);
    pin_exp(4'h7);
    pwm <= 3'h0;
    step(4);
    wr(`CWG_OFS_CONTROL_0, 8'he0);
    wr(`CWG_OFS_SHUTDOWN, 8'h44);
    cmp <= 1'b1;
    step(10);
    rd(`CWG_OFS_SHUTDOWN, 8'hc4);
    pin_exp(4'hd);
    wr(`CWG_OFS_CONTROL_1, 8'h52);
    step(10);
    pin_exp(4'h0);
    cmp <= 1'b0;
    step(10);
    rd(`CWG_OFS_SHUTDOWN, 8'h44);
    wr(`CWG_OFS_SHUTDOWN, 8'h00);
    wr(`CWG_OFS_CONTROL_1, 8'h00);
    pin_exp(4'h5);
    for (i = 0; i < 8; i++) begin
      wr(`CWG_OFS_CONTROL_1, 8'(i));
      {pwm, cmp} <= 4'hf;
      step(12);
      pin_exp((i == 1 || i > 4) ? 4'h7 : 4'hd);
      {pwm, cmp} <= 4'h0;
      step(12);
      pin_exp(4'h7);
    end
    wr(`CWG_OFS_CONTROL_0, 8'h60);
    pin_exp(4'h0);
    srst <= 1'b1;
    step(1);
    srst <= 1'b0;
    step(1);
    pin_exp(4'h0);
    rd(`CWG_OFS_CONTROL_0, 8'h00);
    wrap_up();
  end
endmodule : tb_top
